// File: verilog/output_path_filter_and_volume.sv
// Output-path hi-fi filter select and digital volume with gain ramps.
// Assumes an APB master on REF_CLK; path outputs feed the sample engine.
//
// Contract
// - Per-path filter enable, bit 14, reset 0.
// - One 4-bit filter type, bits 3:0, shared.
// - Types 0-1 deep stopband, 2-3 antialias.
// - Types 4-B: two groups, each non-apodizing then apodizing.
// - Types C-F non-interpolating, four variants.
// - Volume bits 7:0, reset 0x80, half-dB steps.
// - Per-path mute bit 8, reset muted.
// - Gain changes ramp; rise and fall rates.
// - Fall rate bits 6:4, rise 2:0, reset 010.
// - Rate codes give time per 6 dB.
// - Volume writes stay pending until update.
// - Update bit 9 applies all paths together.
// - Internal gain moves in 0.125 dB steps.
// - PDM path sits 6 dB below core.
// - One filter type active, per-path enables.
// - Type change with filter on interrupts briefly.
module output_path_filter_and_volume
  import out_path_pkg::*;
#(
  parameter int STEP_CYC_8MS  = step_cycles(RAMP_TIME_US[5]),
  parameter int STEP_CYC_15MS = step_cycles(RAMP_TIME_US[6]),
  parameter int STEP_CYC_30MS = step_cycles(RAMP_TIME_US[7]),
  parameter int RELOAD_CYC    = RELOAD_CYCLES
) (
  // Clock and reset
  input  wire logic                  REF_CLK,
  input  wire logic                  SYS_RST,
  // APB slave
  input  wire logic                  PSEL,
  input  wire logic                  PENABLE,
  input  wire logic                  PWRITE,
  input  wire logic [ADDR_W-1:0]     PADDR,
  input  wire logic [DATA_W-1:0]     PWDATA,
  output logic      [DATA_W-1:0]     PRDATA,
  output logic                       PREADY,
  output logic                       PSLVERR,
  // Shared filter selection
  output logic      [3:0]            FILTER_TYPE,
  output logic      [2:0]            FILTER_FAMILY,
  output logic                       FILTER_MIN_PHASE,
  output logic                       FILTER_APODIZING,
  output logic                       FILTER_NONINTERP,
  output logic                       FILTER_RELOAD,
  // Per-path state, 0..7 = 1L 1R 2L 2R 3L 3R 5L 5R
  output logic      [NUM_PATHS-1:0]  PATH_FILTER_ON,
  output logic      [NUM_PATHS-1:0]  PATH_SILENT,
  output logic      [NUM_PATHS-1:0]  PATH_RAMPING,
  output logic [NUM_PATHS-1:0][GAIN_W-1:0] PATH_GAIN
);

  // Register state
  logic [2:0]           rise_rate_reg;
  logic [2:0]           fall_rate_reg;
  logic [3:0]           type_reg;
  logic [NUM_PATHS-1:0] filt_en_reg;
  logic [7:0]           pend_vol_reg  [NUM_PATHS];
  logic [NUM_PATHS-1:0] pend_mute_reg;
  logic [7:0]           act_vol_reg   [NUM_PATHS];
  logic [NUM_PATHS-1:0] act_mute_reg;
  logic [7:0]           pend_vol_next [NUM_PATHS];
  logic [NUM_PATHS-1:0] pend_mute_next;

  // Bus decode
  logic [IDX_W-1:0]     idx;
  logic                 aligned;
  logic                 access;
  logic                 wr;
  logic [NUM_PATHS-1:0] hit_cfg;
  logic [NUM_PATHS-1:0] hit_vol;
  logic                 hit_ramp;
  logic                 hit_filter;
  logic                 hit_status;
  logic                 mapped;
  logic                 update;
  logic [DATA_W-1:0]    rdata;

  // Ramp timing and path state from the ramp engines
  logic [CNT_W-1:0]      rise_cyc;
  logic [CNT_W-1:0]      fall_cyc;
  logic [NUM_PATHS-1:0]  silent;
  logic [NUM_PATHS-1:0]  ramping;
  logic [GAIN_W-1:0]     gain [NUM_PATHS];
  logic [$clog2(RELOAD_CYCLES+1)+4:0] reload_cnt_reg;
  logic [2:0]            family;

  // Address decode; registers sit at four times their index
  assign idx        = PADDR[IDX_W+1:2];
  assign aligned    = PADDR[1:0] == 2'b00;
  assign access     = PSEL && PENABLE && PREADY;
  assign wr         = access && PWRITE;
  assign hit_ramp   = aligned && (idx == IDX_RAMP);
  assign hit_filter = aligned && (idx == IDX_FILTER);
  assign hit_status = aligned && (idx == IDX_STATUS);
  assign mapped     = hit_ramp || hit_filter || hit_status
                      || (|hit_cfg) || (|hit_vol);

  // Per-path decode hits
  always_comb begin
    for (int p = 0; p < NUM_PATHS; p++) begin
      hit_cfg[p] = aligned && (idx == CFG_IDX[p]);
      hit_vol[p] = aligned && (idx == VOL_IDX[p]);
    end
  end

  // Update strobe: any volume register written with bit 9 set
  assign update = wr && (|hit_vol) && PWDATA[UPDATE_BIT];

  // Pending values after this cycle's write; the written value joins
  // the update that it carries
  always_comb begin
    for (int p = 0; p < NUM_PATHS; p++) begin
      pend_vol_next[p]  = pend_vol_reg[p];
      pend_mute_next[p] = pend_mute_reg[p];
      if (wr && hit_vol[p]) begin
        pend_vol_next[p]  = PWDATA[7:0];
        pend_mute_next[p] = PWDATA[MUTE_BIT];
      end
    end
  end

  // APB handshake: one wait state so read data leaves a flip-flop
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= '0;
    end else begin
      PREADY  <= PSEL && PENABLE && !PREADY;
      PSLVERR <= PSEL && PENABLE && !PREADY && !mapped;
      PRDATA  <= (PSEL && PENABLE && !PREADY && !PWRITE) ? rdata : '0;
    end
  end

  // Read mux; update bit is write-only and reads zero
  always_comb begin
    rdata = '0;
    if (hit_ramp) begin
      rdata[FALL_LSB +: 3] = fall_rate_reg;
      rdata[RISE_LSB +: 3] = rise_rate_reg;
    end
    if (hit_filter) begin
      rdata[3:0] = type_reg;
    end
    if (hit_status) begin
      rdata[NUM_PATHS-1:0]            = ramping;
      rdata[SILENT_LSB +: NUM_PATHS]  = silent;
    end
    for (int p = 0; p < NUM_PATHS; p++) begin
      if (hit_cfg[p]) begin
        rdata[FILT_EN_BIT] = filt_en_reg[p];
      end
      if (hit_vol[p]) begin
        rdata[7:0]      = pend_vol_reg[p];
        rdata[MUTE_BIT] = pend_mute_reg[p];
      end
    end
  end

  // Ramp rate register; software leaves it alone mid-ramp
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      rise_rate_reg <= RATE_RST;
      fall_rate_reg <= RATE_RST;
    end else if (wr && hit_ramp) begin
      rise_rate_reg <= PWDATA[RISE_LSB +: 3];
      fall_rate_reg <= PWDATA[FALL_LSB +: 3];
    end
  end

  // Filter type and per-path enables
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      type_reg    <= TYPE_RST;
      filt_en_reg <= {NUM_PATHS{FILT_RST}};
    end else begin
      if (wr && hit_filter) begin
        type_reg <= PWDATA[3:0];
      end
      for (int p = 0; p < NUM_PATHS; p++) begin
        if (wr && hit_cfg[p]) begin
          filt_en_reg[p] <= PWDATA[FILT_EN_BIT];
        end
      end
    end
  end

  // Pending and applied volume; applied only moves on the update strobe
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      pend_mute_reg <= {NUM_PATHS{MUTE_RST}};
      act_mute_reg  <= {NUM_PATHS{MUTE_RST}};
      for (int p = 0; p < NUM_PATHS; p++) begin
        pend_vol_reg[p] <= VOL_RST;
        act_vol_reg[p]  <= VOL_RST;
      end
    end else begin
      pend_mute_reg <= pend_mute_next;
      for (int p = 0; p < NUM_PATHS; p++) begin
        pend_vol_reg[p] <= pend_vol_next[p];
      end
      if (update) begin
        act_mute_reg <= pend_mute_next;
        for (int p = 0; p < NUM_PATHS; p++) begin
          act_vol_reg[p] <= pend_vol_next[p];
        end
      end
    end
  end

  // Rate code to cycles per fine step; the long ones are parameters
  function automatic logic [CNT_W-1:0] rate_cycles(input logic [2:0] code);
    case (code)
      3'h0:    return '0;
      3'h1:    return CNT_W'(step_cycles(RAMP_TIME_US[1]));
      3'h2:    return CNT_W'(step_cycles(RAMP_TIME_US[2]));
      3'h3:    return CNT_W'(step_cycles(RAMP_TIME_US[3]));
      3'h4:    return CNT_W'(step_cycles(RAMP_TIME_US[4]));
      3'h5:    return CNT_W'(STEP_CYC_8MS);
      3'h6:    return CNT_W'(STEP_CYC_15MS);
      default: return CNT_W'(STEP_CYC_30MS);
    endcase
  endfunction

  assign rise_cyc = rate_cycles(rise_rate_reg);
  assign fall_cyc = rate_cycles(fall_rate_reg);

  // One ramp engine per path; PDM paths sit 6 dB lower on the same scale
  generate
    for (genvar p = 0; p < NUM_PATHS; p++) begin : g_path
      path_gain_ramp #(
        .FLOOR (PDM_PATH[p] ? PDM_FLOOR : ANALOG_FLOOR)
      ) u_ramp (
        .clk         (REF_CLK),
        .rst         (SYS_RST),
        .target_code (act_vol_reg[p]),
        .mute        (act_mute_reg[p]),
        .rise_cyc    (rise_cyc),
        .fall_cyc    (fall_cyc),
        .gain        (gain[p]),
        .silent      (silent[p]),
        .ramping     (ramping[p])
      );
    end
  endgenerate

  // Family of the shared filter type
  always_comb begin
    if (type_reg >= TYPE_NONINTERP) begin
      family = FAM_NONINTERP;
    end else if (type_reg >= TYPE_GROUP_B) begin
      family = FAM_GROUP_B;
    end else if (type_reg >= TYPE_GROUP_A) begin
      family = FAM_GROUP_A;
    end else if (type_reg[1]) begin
      family = FAM_ANTIALIAS;
    end else begin
      family = FAM_DEEP;
    end
  end

  // Filter outputs; one type serves every enabled path
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      FILTER_TYPE      <= TYPE_RST;
      FILTER_FAMILY    <= FAM_DEEP;
      FILTER_MIN_PHASE <= 1'b0;
      FILTER_APODIZING <= 1'b0;
      FILTER_NONINTERP <= 1'b0;
      PATH_FILTER_ON   <= '0;
    end else begin
      FILTER_TYPE      <= type_reg;
      FILTER_FAMILY    <= family;
      FILTER_MIN_PHASE <= type_reg[0];
      FILTER_APODIZING <= (type_reg >= TYPE_GROUP_A) && type_reg[1];
      FILTER_NONINTERP <= type_reg >= TYPE_NONINTERP;
      PATH_FILTER_ON   <= filt_en_reg;
    end
  end

  // Coefficient reload gap: a changed type with any path filtering
  // holds playback off while the new preset loads
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      reload_cnt_reg <= '0;
      FILTER_RELOAD  <= 1'b0;
    end else begin
      if (wr && hit_filter && (PWDATA[3:0] != type_reg)
          && (|filt_en_reg)) begin
        reload_cnt_reg <= ($bits(reload_cnt_reg))'(RELOAD_CYC);
        FILTER_RELOAD  <= 1'b1;
      end else if (reload_cnt_reg != '0) begin
        reload_cnt_reg <= reload_cnt_reg - 1'b1;
        FILTER_RELOAD  <= reload_cnt_reg != 1;
      end else begin
        FILTER_RELOAD  <= 1'b0;
      end
    end
  end

  // Path state outputs, one cycle behind the ramp engines
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      PATH_SILENT  <= '1;
      PATH_RAMPING <= '0;
      for (int p = 0; p < NUM_PATHS; p++) begin
        PATH_GAIN[p] <= PDM_PATH[p] ? PDM_FLOOR : ANALOG_FLOOR;
      end
    end else begin
      PATH_SILENT  <= silent;
      PATH_RAMPING <= ramping;
      for (int p = 0; p < NUM_PATHS; p++) begin
        PATH_GAIN[p] <= gain[p];
      end
    end
  end

endmodule

// File: shared/out_path_pkg.sv
// Constants for the output-path filter select and digital volume block.
// Assumes a 25 MHz register clock and a 32-bit APB register bus.
package out_path_pkg;

  // Bus shape and path count
  localparam int ADDR_W    = 16;
  localparam int DATA_W    = 32;
  localparam int NUM_PATHS = 8;
  localparam int IDX_W     = 14;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_RAMP   = 14'h0409;
  localparam logic [IDX_W-1:0] IDX_FILTER = 14'h044e;
  localparam logic [IDX_W-1:0] IDX_STATUS = 14'h044f;
  // Path order 0..7: 1L, 1R, 2L, 2R, 3L, 3R, 5L, 5R
  localparam logic [IDX_W-1:0] CFG_IDX [NUM_PATHS] = '{
    14'h0410, 14'h0414, 14'h0418, 14'h041c,
    14'h0420, 14'h0424, 14'h0430, 14'h0434};
  localparam logic [IDX_W-1:0] VOL_IDX [NUM_PATHS] = '{
    14'h0411, 14'h0415, 14'h0419, 14'h041d,
    14'h0421, 14'h0425, 14'h0431, 14'h0435};
  localparam logic [NUM_PATHS-1:0] PDM_PATH = 8'hc0;

  // Field positions
  localparam int FILT_EN_BIT = 14;
  localparam int UPDATE_BIT  = 9;
  localparam int MUTE_BIT    = 8;
  localparam int FALL_LSB    = 4;
  localparam int RISE_LSB    = 0;
  localparam int SILENT_LSB  = 8;

  // Reset values
  localparam logic [7:0] VOL_RST    = 8'h80;
  localparam logic       MUTE_RST   = 1'b1;
  localparam logic       FILT_RST   = 1'b0;
  localparam logic [2:0] RATE_RST   = 3'h2;
  localparam logic [3:0] TYPE_RST   = 4'h0;

  // Gain scale: internal steps of 0.125 dB, four per register code
  localparam int          GAIN_W         = 11;
  localparam int          STEPS_PER_6DB  = 48;
  localparam logic [10:0] ANALOG_FLOOR   = 11'h030;
  localparam logic [10:0] PDM_FLOOR      = 11'h000;

  // Filter type codes and families
  localparam logic [3:0] TYPE_GROUP_A   = 4'h4;
  localparam logic [3:0] TYPE_GROUP_B   = 4'h8;
  localparam logic [3:0] TYPE_NONINTERP = 4'hc;
  typedef enum logic [2:0] {
    FAM_DEEP      = 3'h0,
    FAM_ANTIALIAS = 3'h1,
    FAM_GROUP_A   = 3'h2,
    FAM_GROUP_B   = 3'h3,
    FAM_NONINTERP = 3'h4
  } filter_family_t;

  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int CNT_W         = 14;
  localparam int RELOAD_CYCLES = 16;
  localparam int RAMP_TIME_US [8] = '{0, 500, 1000, 2000,
                                      4000, 8000, 15000, 30000};

  // Cycles per 0.125 dB step for a time per 6 dB, rounded down
  function automatic int step_cycles(input int time_us);
    return (time_us * 1000) / (CLK_PERIOD_NS * STEPS_PER_6DB);
  endfunction

endpackage

// File: verilog/path_gain_ramp.sv
// One output path's gain ramp, stepping 0.125 dB at a time, or jumping straight to the target when the rate code is 0.
// Assumes target and mute come from the applied (not pending) settings.
module path_gain_ramp
  import out_path_pkg::*;
#(
  parameter logic [10:0] FLOOR = ANALOG_FLOOR
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Applied settings and step periods
  input  wire logic [7:0]        target_code,
  input  wire logic              mute,
  input  wire logic [CNT_W-1:0]  rise_cyc,
  input  wire logic [CNT_W-1:0]  fall_cyc,
  // Gain state
  output logic [GAIN_W-1:0]      gain,
  output logic                   silent,
  output logic                   ramping
);

  logic [GAIN_W-1:0] target;
  logic [GAIN_W-1:0] gain_next;
  logic [CNT_W-1:0]  cnt_reg;
  logic [CNT_W-1:0]  cnt_next;
  logic [CNT_W-1:0]  cyc;
  logic              up;

  // Mute ramps to the floor; codes sit four fine steps apart
  assign target = mute ? FLOOR : GAIN_W'(FLOOR + {1'b0, target_code, 2'b00});
  assign up     = target > gain;
  assign cyc    = up ? rise_cyc : fall_cyc;

  // One fine step per period; a new target is chased from where we are
  always_comb begin
    gain_next = gain;
    cnt_next  = '0;
    if (gain != target) begin
      if (cyc == '0) begin
        gain_next = target; // Zero time per 6 dB jumps at once
      end else if (cnt_reg + 1'b1 >= cyc) begin
        gain_next = up ? GAIN_W'(gain + 1'b1) : GAIN_W'(gain - 1'b1);
      end else begin
        cnt_next = CNT_W'(cnt_reg + 1'b1);
      end
    end
  end

  // Ramp state
  always_ff @(posedge clk) begin
    if (rst) begin
      gain    <= FLOOR;
      cnt_reg <= '0;
      silent  <= 1'b1;
      ramping <= 1'b0;
    end else begin
      gain    <= gain_next;
      cnt_reg <= cnt_next;
      silent  <= mute && (gain_next == FLOOR); // Silence only once faded
      ramping <= gain_next != target;
    end
  end

endmodule

// File: tb/out_path_sva.sv
// Checker for the output-path block, bound to its top module.
// Assumes one clock domain and a synchronous active-high reset.
module out_path_sva
  import out_path_pkg::*;
(
  // Clock, reset and bus
  input wire logic              REF_CLK,
  input wire logic              SYS_RST,
  input wire logic              PSEL,
  input wire logic              PENABLE,
  input wire logic              PWRITE,
  input wire logic [DATA_W-1:0] PWDATA,
  input wire logic              PREADY,
  // Filter and path state
  input wire logic [3:0]        FILTER_TYPE,
  input wire logic [2:0]        FILTER_FAMILY,
  input wire logic              FILTER_MIN_PHASE,
  input wire logic              FILTER_APODIZING,
  input wire logic              FILTER_NONINTERP,
  input wire logic              FILTER_RELOAD,
  input wire logic [7:0]        PATH_SILENT,
  input wire logic [7:0]        PATH_RAMPING,
  input wire logic [7:0][10:0]  PATH_GAIN
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  logic upd;
  logic upd_d;
  logic upd_d2;
  // Update write completing now; its effect lands two edges later
  assign upd = PSEL && PENABLE && PREADY && PWRITE && PWDATA[UPDATE_BIT];
  // Delayed copies so the check skips every cycle up to the landing
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      upd_d  <= 1'b0;
      upd_d2 <= 1'b0;
    end else begin
      upd_d  <= upd;
      upd_d2 <= upd_d;
    end
  end
  wait_state_a: assert property (PSEL && PENABLE && !$past(PENABLE)
    |-> !PREADY ##1 PREADY) else $error("bus wait state wrong");
  noninterp_a: assert property (FILTER_NONINTERP == (FILTER_TYPE >= 4'hc))
    else $error("non-interpolating flag wrong");
  min_phase_a: assert property (FILTER_MIN_PHASE == FILTER_TYPE[0])
    else $error("phase flag wrong");
  family_map_a: assert property (FILTER_FAMILY == ((FILTER_TYPE < 4'h2) ?
    3'h0 : (FILTER_TYPE < 4'h4) ? 3'h1 : {1'b0, FILTER_TYPE[3:2]} + 3'h1))
    else $error("filter family wrong");
  apodizing_a: assert property (FILTER_APODIZING ==
    (FILTER_TYPE >= 4'h4 && FILTER_TYPE[1])) else $error("apodizing wrong");
  reload_hold_a: assert property ($rose(FILTER_RELOAD) |->
    FILTER_RELOAD[*8]) else $error("reload gap too short");
  pending_hold_a: assert property (!PATH_RAMPING[0] && !upd && !upd_d
    && !upd_d2 |=> $stable(PATH_GAIN[0]))
    else $error("gain moved without update");
  gain_step_a: assert property (PATH_RAMPING[0] && $past(PATH_RAMPING[0])
    |-> PATH_GAIN[0] == $past(PATH_GAIN[0]) ||
        PATH_GAIN[0] == $past(PATH_GAIN[0]) + 11'h001 ||
        PATH_GAIN[0] + 11'h001 == $past(PATH_GAIN[0]))
    else $error("gain step above one unit");
  silent_floor_a: assert property (PATH_SILENT[0] |->
    PATH_GAIN[0] == ANALOG_FLOOR) else $error("silent above floor");
  pdm_ceiling_a: assert property (PATH_GAIN[6] <= 11'h2fc)
    else $error("pdm gain above ceiling");
  // Main scenarios reached
  cover property (upd);
  cover property ($rose(FILTER_RELOAD));
  cover property ($rose(PATH_RAMPING[0]));
endmodule

// File: tb/mixer_model.sv
// Model of the mixer feeding the output paths.
// Assumes it withholds samples while the filter preset reloads.
module mixer_model (
  // Clock and reset
  input wire logic  clk,
  input wire logic  rst,
  // Reload gap from the block
  input wire logic  reload,
  output logic [15:0] held
);
  timeunit 1ns;
  timeprecision 1ns;
  // Count sample slots lost to a reload; playback stalls meanwhile
  always_ff @(posedge clk) begin
    if (rst) held <= 16'h0000;
    else if (reload) held <= held + 16'h0001;
  end
endmodule

// File: tb/output_path_filter_and_volume_test.sv
// Testbench for the output-path filter select and volume block.
// Assumes the package constants and an APB master on one clock.
module output_path_filter_and_volume_test
  import out_path_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int RISE1 = 500000 / (CLK_PERIOD_NS * STEPS_PER_6DB);
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, err;
  logic [3:0] ftype;
  logic [2:0] ffam;
  logic fmin, fapo, fnon, freload;
  logic [7:0] fon, silent, ramping;
  logic [7:0][10:0] gain;
  logic [15:0] held;
  int bad_count = 0;
  int tests_run = 0;
  // Free-running 25 MHz clock
  always #20 clk = ~clk;
  output_path_filter_and_volume u_output_path_filter_and_volume (
    .REF_CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .FILTER_TYPE(ftype),
    .FILTER_FAMILY(ffam), .FILTER_MIN_PHASE(fmin),
    .FILTER_APODIZING(fapo), .FILTER_NONINTERP(fnon),
    .FILTER_RELOAD(freload), .PATH_FILTER_ON(fon), .PATH_SILENT(silent),
    .PATH_RAMPING(ramping), .PATH_GAIN(gain));
  mixer_model u_mixer_model (.clk(clk), .rst(rst), .reload(freload),
    .held(held));
  task automatic chk_reg(input logic [31:0] got, exp, input string s);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s %h not %h", $time, s, got, exp);
    end
  endtask
  task automatic chk_gain(input logic [10:0] got, exp, input string s);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s %0d not %0d", $time, s, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One APB transfer; holds the request until pready is seen
  task automatic apb(input logic w, input logic [13:0] idx,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      $display("unexpected at %0t: no pready", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [13:0] idx, input logic [31:0] e);
    apb(1'b0, idx, 32'h0);
    chk_reg(rd, e, "read");
  endtask
  task automatic settle(output int n);
    n = 3;
    while (ramping[0] === 1'b1 && n < 2000) begin
      cyc(1);
      n++;
    end
    if (n >= 2000) begin
      bad_count++;
      $display("unexpected at %0t: ramp never settled", $time);
    end
  endtask
  // Gain in eighth-dB units for a volume code
  function automatic logic [10:0] g(input int c, input bit pdm);
    return 11'(4 * c + (pdm ? 0 : 48));
  endfunction
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Watchdog well beyond the few thousand cycles the tests need
  initial begin
    cyc(20000);
    bad_count++;
    $display("unexpected at %0t: watchdog", $time);
    summarize;
  end
  // Test sequence
  initial begin
    int n;
    logic [10:0] g0;
    cyc(20);
    rst <= 1'b0;
    rdchk(IDX_RAMP, 32'h22);
    rdchk(IDX_FILTER, 32'h0);
    for (int i = 0; i < NUM_PATHS; i++) begin
      rdchk(CFG_IDX[i], 32'h0);
      rdchk(VOL_IDX[i], 32'h180);
      chk_gain(gain[i], g(0, PDM_PATH[i]), "floor");
    end
    $display("test reset done");
    for (int c = 0; c < 16; c++) begin
      apb(1'b1, IDX_FILTER, 32'(c));
      cyc(2);
      chk_reg({22'h0, ftype, ffam, fmin, fapo, fnon}, {22'h0, 4'(c),
        (c < 2) ? 3'h0 : (c < 4) ? 3'h1 : 3'(c / 4 + 1), c[0],
        c >= 4 && c[1], c >= 12}, "type");
      rdchk(IDX_FILTER, 32'(c));
    end
    chk_reg({16'h0, held}, 32'h0, "no gap");
    $display("test filter types done");
    apb(1'b1, CFG_IDX[2], 32'h4000);
    apb(1'b1, CFG_IDX[7], 32'h4000);
    cyc(2);
    chk_reg({24'h0, fon}, 32'h84, "enables");
    apb(1'b1, IDX_FILTER, 32'h3);
    cyc(RELOAD_CYCLES + 4);
    chk_reg({16'h0, held}, 32'(RELOAD_CYCLES), "gap");
    apb(1'b1, CFG_IDX[2], 32'h0);
    apb(1'b1, CFG_IDX[7], 32'h0);
    $display("test filter reload done");
    apb(1'b1, IDX_RAMP, 32'h0);
    apb(1'b1, VOL_IDX[0], 32'h040);
    cyc(4);
    chk_gain(gain[0], g(0, 0), "pending");
    rdchk(VOL_IDX[0], 32'h040);
    apb(1'b1, VOL_IDX[1], 32'h0bf);
    apb(1'b1, VOL_IDX[6], 32'h280);
    cyc(4);
    chk_gain(gain[0], g('h40, 0), "apply");
    chk_gain(gain[1], g('hbf, 0), "top");
    chk_gain(gain[6], g('h80, 1), "pdm");
    chk_reg({24'h0, silent}, 32'hbc, "silent");
    rdchk(VOL_IDX[6], 32'h080);
    $display("test update done");
    apb(1'b1, IDX_RAMP, 32'h01);
    apb(1'b1, VOL_IDX[0], 32'h241);
    cyc(3);
    chk_reg({31'h0, ramping[0]}, 32'h1, "ramping");
    settle(n);
    chk_gain(gain[0], g('h41, 0), "rise end");
    chk_reg({31'h0, n > 3 * RISE1 && n <= 4 * RISE1 + 8}, 1, "time");
    apb(1'b1, VOL_IDX[0], 32'h248);
    cyc(3 * RISE1);
    apb(1'b1, VOL_IDX[0], 32'h243);
    g0 = gain[0];
    cyc(4);
    chk_reg({31'h0, gain[0] - g0 <= 11'h001}, 1, "no jump");
    settle(n);
    chk_gain(gain[0], g('h43, 0), "retarget");
    $display("test ramp done");
    apb(1'b1, IDX_RAMP, 32'h10);
    rdchk(IDX_RAMP, 32'h10);
    apb(1'b1, VOL_IDX[0], 32'h244);
    cyc(4);
    chk_gain(gain[0], g('h44, 0), "rise jump");
    apb(1'b1, VOL_IDX[0], 32'h243);
    cyc(3);
    chk_reg({31'h0, ramping[0]}, 32'h1, "falling");
    settle(n);
    chk_gain(gain[0], g('h43, 0), "fall end");
    chk_reg({31'h0, n > 3 * RISE1 && n <= 4 * RISE1 + 8}, 1,
      "fall");
    $display("test fall ramp done");
    apb(1'b1, IDX_RAMP, 32'h0);
    apb(1'b1, VOL_IDX[0], 32'h343);
    cyc(4);
    chk_gain(gain[0], g(0, 0), "mute");
    chk_reg({31'h0, silent[0]}, 32'h1, "mute silent");
    apb(1'b0, 14'h0400, 32'h0);
    chk_reg({31'h0, err}, 32'h1, "unmapped");
    chk_reg(rd, 32'h0, "unmapped data");
    rdchk(IDX_STATUS, 32'hbd00);
    $display("test mute and unmapped done");
    summarize;
  end
endmodule
bind output_path_filter_and_volume out_path_sva u_out_path_sva (
  .REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PWDATA(PWDATA), .PREADY(PREADY),
  .FILTER_TYPE(FILTER_TYPE), .FILTER_FAMILY(FILTER_FAMILY),
  .FILTER_MIN_PHASE(FILTER_MIN_PHASE), .FILTER_APODIZING(FILTER_APODIZING),
  .FILTER_NONINTERP(FILTER_NONINTERP), .FILTER_RELOAD(FILTER_RELOAD),
  .PATH_SILENT(PATH_SILENT), .PATH_RAMPING(PATH_RAMPING),
  .PATH_GAIN(PATH_GAIN));
